/* hdl/rcs_top.sv */
// reset and clock source select: supply good, combined reset, clock routing
// Behaviour
// - with the regulator strap low the regulator is enabled and supply good rises only when its output is above threshold.
// - the combined reset is the AND of supply good and the active-low reset pin.
// - with the regulator strap high monitoring is bypassed, supply good is forced high and only the pin resets.
// - with the regulator on, its level is chosen by the voltage select bit of the regulator control register.
// - with the clock-source strap low the internal oscillator feeds both the timer and the clock generator.
// - with the clock-source strap high the external input feeds the clock generator, the oscillator only the timer.
// - in deep idle the clock generator is bypassed and the system clock is the strap-chosen source.
// - the boot sequence begins when the combined reset is released.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
module rcs_top
    import rcs_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        core_regulator_enable_strap_in,
    input  wire logic        clock_source_strap_in,
    input  wire logic        reset_pin_n_in,
    input  wire logic        core_regulator_output_above_threshold_in,
    input  wire logic        deep_idle_mode_in,
    input  wire logic        external_clock_input_in,
    input  wire logic        rtc_oscillator_in,
    input  wire logic        clock_generator_in,
    output logic             core_regulator_enable_out,
    output logic             core_voltage_select_out,
    output logic             supply_good_out,
    output logic             hw_reset_n_out,
    output logic             boot_start_out,
    output logic             clock_generator_ref_out,
    output logic             rtc_timer_clock_out,
    output logic             system_clock_out,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import rcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture at reset release
    logic       straps_valid_r;
    logic       straps_valid_nxt;
    logic       reg_strap_r;
    logic       reg_strap_nxt;
    logic       clk_strap_r;
    logic       clk_strap_nxt;

    always_comb begin
        straps_valid_nxt = 1'b1;
        reg_strap_nxt    = straps_valid_r ? reg_strap_r : core_regulator_enable_strap_in;
        clk_strap_nxt    = straps_valid_r ? clk_strap_r : clock_source_strap_in;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            straps_valid_r <= 1'b0;
            reg_strap_r    <= 1'b1;
            clk_strap_r    <= 1'b0;
        end else begin
            straps_valid_r <= straps_valid_nxt;
            reg_strap_r    <= reg_strap_nxt;
            clk_strap_r    <= clk_strap_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // regulator control and supply good
    logic       vsel_r;
    logic       vsel_nxt;
    logic [2:0] good_cnt_r;
    logic [2:0] good_cnt_nxt;
    logic       good_r;
    logic       good_nxt;
    logic       reg_on;

    assign reg_on = ~reg_strap_r;

    always_comb begin
        good_cnt_nxt = good_cnt_r;
        good_nxt     = good_r;
        if (!straps_valid_r) begin
            good_cnt_nxt = 3'h0;
            good_nxt     = 1'b0;
        end else if (!reg_on) begin
            good_cnt_nxt = 3'h0;
            good_nxt     = 1'b1;
        end else if (!core_regulator_output_above_threshold_in) begin
            good_cnt_nxt = 3'h0;
            good_nxt     = 1'b0;
        end else if (good_cnt_r != 3'(GOOD_FILTER_CYCLES)) begin
            good_cnt_nxt = good_cnt_r + 3'h1;
        end else begin
            good_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            good_cnt_r <= 3'h0;
            good_r     <= 1'b0;
        end else begin
            good_cnt_r <= good_cnt_nxt;
            good_r     <= good_nxt;
        end
    end

    assign core_regulator_enable_out = straps_valid_r & reg_on;
    assign core_voltage_select_out   = vsel_r;
    assign supply_good_out           = good_r;

    ////////////////////////////////////////////////////////////////////////////
    // combined reset, synchronised release, boot start
    rcs_sync_if sync_if ();
    logic       hold_comb;
    rcs_state_t state_r;
    rcs_state_t state_nxt;
    logic       boot_nxt;

    assign hold_comb = rst_in | ~straps_valid_r | ~(good_r & reset_pin_n_in);

    assign sync_if.hold_req = hold_comb;

    rcs_reset_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clock_in (clock_in),
        .sync     (sync_if.snk)
    );

    always_comb begin
        state_nxt = state_r;
        boot_nxt  = 1'b0;
        case (state_r)
            RCS_HELD: begin
                if (sync_if.released) begin
                    state_nxt = RCS_RELEASING;
                end
            end
            RCS_RELEASING: begin
                state_nxt = RCS_RUN;
                boot_nxt  = 1'b1;
            end
            default: begin
                if (!sync_if.released) begin
                    state_nxt = RCS_HELD;
                end
            end
        endcase
        if (!sync_if.released) begin
            state_nxt = RCS_HELD;
            boot_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_r        <= RCS_HELD;
            boot_start_out <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            boot_start_out <= boot_nxt;
        end
    end

    assign hw_reset_n_out = sync_if.released;

    ////////////////////////////////////////////////////////////////////////////
    // clock source routing
    always_comb begin
        rtc_timer_clock_out     = rtc_oscillator_in;
        clock_generator_ref_out = clk_strap_r ? external_clock_input_in
                                              : rtc_oscillator_in;
        if (deep_idle_mode_in) begin
            system_clock_out = clock_generator_ref_out;
        end else begin
            system_clock_out = clock_generator_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic        aw_held_r;
    logic        aw_held_nxt;
    logic [11:0] awaddr_r;
    logic [11:0] awaddr_nxt;
    logic        w_held_r;
    logic        w_held_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic        wstrb0_r;
    logic        wstrb0_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;
    logic [31:0] status_word;

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_comb begin
        status_word                   = 32'h0000_0000;
        status_word[STAT_BIT_GOOD]    = good_r;
        status_word[STAT_BIT_RESET_N] = sync_if.released;
        status_word[STAT_BIT_REG_ON]  = reg_on;
        status_word[STAT_BIT_EXT_SRC] = clk_strap_r;
        status_word[STAT_BIT_BYPASS]  = deep_idle_mode_in;
        status_word[STAT_BIT_VSEL]    = vsel_r;
        status_word[STAT_BIT_BOOT]    = (state_r == RCS_RUN);
    end

    always_comb begin
        aw_held_nxt = aw_held_r;
        awaddr_nxt  = awaddr_r;
        w_held_nxt  = w_held_r;
        wdata_nxt   = wdata_r;
        wstrb0_nxt  = wstrb0_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        vsel_nxt    = vsel_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb0_nxt = s_axi_wstrb[0];
        end
        if (aw_held_r && w_held_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            if (awaddr_r[11:2] == ADDR_REG_CTRL[11:2]) begin
                bresp_nxt = RESP_OKAY;
                if (wstrb0_r) begin
                    vsel_nxt = wdata_r[VSEL_BIT];
                end
            end else if (awaddr_r[11:2] == ADDR_STATUS[11:2]
                         || awaddr_r[11:2] == ADDR_STRAPS[11:2]) begin
                bresp_nxt = RESP_OKAY;
            end else begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            if (s_axi_araddr[11:2] == ADDR_REG_CTRL[11:2]) begin
                rdata_nxt           = 32'h0000_0000;
                rdata_nxt[VSEL_BIT] = vsel_r;
            end else if (s_axi_araddr[11:2] == ADDR_STATUS[11:2]) begin
                rdata_nxt = status_word;
            end else if (s_axi_araddr[11:2] == ADDR_STRAPS[11:2]) begin
                rdata_nxt                    = 32'h0000_0000;
                rdata_nxt[STRAP_BIT_REG_EN]  = reg_strap_r;
                rdata_nxt[STRAP_BIT_CLK_SEL] = clk_strap_r;
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 12'h000;
            w_held_r  <= 1'b0;
            wdata_r   <= 32'h0000_0000;
            wstrb0_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            vsel_r    <= REG_CTRL_RESET[VSEL_BIT];
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            awaddr_r  <= awaddr_nxt;
            w_held_r  <= w_held_nxt;
            wdata_r   <= wdata_nxt;
            wstrb0_r  <= wstrb0_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            vsel_r    <= vsel_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end
endmodule : rcs_top

/* hdl/rcs_pkg.sv */
// constants and types for the reset and clock source select block
package rcs_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 5;
    localparam int unsigned RESET_LOW_WIDTH_P  = 3;
    localparam int unsigned SYNC_STAGES        = 2;
    localparam int unsigned GOOD_FILTER_CYCLES = 4;
    localparam int unsigned VSEL_BIT           = 0;
    localparam int unsigned STRAP_BIT_REG_EN   = 0;
    localparam int unsigned STRAP_BIT_CLK_SEL  = 1;
    localparam int unsigned STAT_BIT_GOOD      = 0;
    localparam int unsigned STAT_BIT_RESET_N   = 1;
    localparam int unsigned STAT_BIT_REG_ON    = 2;
    localparam int unsigned STAT_BIT_EXT_SRC   = 3;
    localparam int unsigned STAT_BIT_BYPASS    = 4;
    localparam int unsigned STAT_BIT_VSEL      = 5;
    localparam int unsigned STAT_BIT_BOOT      = 6;
    localparam logic [11:0] ADDR_REG_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS        = 12'h004;
    localparam logic [11:0] ADDR_STRAPS        = 12'h008;
    localparam logic [31:0] REG_CTRL_RESET     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY          = 2'b00;
    localparam logic [1:0]  RESP_SLVERR        = 2'b10;
    typedef enum logic [1:0] {
        RCS_HELD,
        RCS_RELEASING,
        RCS_RUN
    } rcs_state_t;
endpackage : rcs_pkg

/* hdl/rcs_sync_if.sv */
// interface carrying the asynchronous reset request into the release synchroniser
interface rcs_sync_if;
    logic hold_req;
    logic released;
    modport src (output hold_req, input released);
    modport snk (input hold_req, output released);
endinterface : rcs_sync_if

/* hdl/rcs_reset_sync.sv */
// reset release synchroniser: asserts at once, releases after a few clean edges
module rcs_reset_sync #(
    parameter int unsigned STAGES = 2
) (
    input  wire logic clock_in,
    rcs_sync_if.snk       sync
);
    logic [STAGES-1:0] chain_r;
    logic [STAGES-1:0] chain_nxt;

    always_comb begin
        chain_nxt = {chain_r[STAGES-2:0], 1'b1};
    end

    always_ff @(posedge clock_in or posedge sync.hold_req) begin
        if (sync.hold_req) begin
            chain_r <= '0;
        end else begin
            chain_r <= chain_nxt;
        end
    end

    assign sync.released = chain_r[STAGES-1];
endmodule : rcs_reset_sync

/* sim/rcs_board_model.sv */
// board straps and external reset supervisor model
module rcs_board_model (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic reg_strap_cfg_in,
    input  wire logic clk_strap_cfg_in,
    input  wire logic pulse_req_in,
    output logic      core_regulator_enable_strap_out,
    output logic      clock_source_strap_out,
    output logic      reset_pin_n_out
);
    import rcs_pkg::*;
    logic [3:0] low_cnt_r = 4'(RESET_LOW_WIDTH_P + 1);
    initial begin
        core_regulator_enable_strap_out = 1'b1;
        clock_source_strap_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clock_in) begin
        if (rst_in) begin
            core_regulator_enable_strap_out <= reg_strap_cfg_in;
            clock_source_strap_out <= clk_strap_cfg_in;
        end
        if (pulse_req_in) begin
            low_cnt_r <= 4'(RESET_LOW_WIDTH_P + 1);
        end else if (low_cnt_r != 4'h0) begin
            low_cnt_r <= low_cnt_r - 4'h1;
        end
    end
    assign reset_pin_n_out = (low_cnt_r == 4'h0);
endmodule // rcs_board_model

/* sim/rcs_top_checker.sv */
// port assertions for the reset and clock source select block
module rcs_top_checker (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clock_source_strap_in,
    input wire logic reset_pin_n_in,
    input wire logic core_regulator_output_above_threshold_in,
    input wire logic deep_idle_mode_in,
    input wire logic external_clock_input_in,
    input wire logic rtc_oscillator_in,
    input wire logic clock_generator_in,
    input wire logic core_regulator_enable_out,
    input wire logic core_voltage_select_out,
    input wire logic supply_good_out,
    input wire logic hw_reset_n_out,
    input wire logic boot_start_out,
    input wire logic clock_generator_ref_out,
    input wire logic rtc_timer_clock_out,
    input wire logic system_clock_out,
    input wire logic s_axi_bvalid
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    property p_reg_fall;
        core_regulator_enable_out && !core_regulator_output_above_threshold_in
            |-> ##1 !supply_good_out;
    endproperty
    a_reg_fall: assert property (p_reg_fall) else $error("supply good not dropped");
    property p_reg_rise;
        $rose(supply_good_out) && core_regulator_enable_out |->
            $past(core_regulator_output_above_threshold_in, 1) &&
            $past(core_regulator_output_above_threshold_in, 2) &&
            $past(core_regulator_output_above_threshold_in, 3) &&
            $past(core_regulator_output_above_threshold_in, 4);
    endproperty
    a_reg_rise: assert property (p_reg_rise) else $error("supply good rose early");
    property p_pin_hold;
        !reset_pin_n_in || !supply_good_out |-> ##1 !hw_reset_n_out;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("reset not held");
    property p_bypass;
        !core_regulator_enable_out [*3] |-> ##1 supply_good_out;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass supply good low");
    property p_vsel;
        $changed(core_voltage_select_out) |-> $rose(s_axi_bvalid);
    endproperty
    a_vsel: assert property (p_vsel) else $error("voltage select moved alone");
    property p_ref_mux;
        hw_reset_n_out |-> clock_generator_ref_out ==
            (clock_source_strap_in ? external_clock_input_in : rtc_oscillator_in);
    endproperty
    a_ref_mux: assert property (p_ref_mux) else $error("reference source wrong");
    property p_rtc;
        rtc_timer_clock_out == rtc_oscillator_in;
    endproperty
    a_rtc: assert property (p_rtc) else $error("timer clock wrong");
    property p_idle;
        system_clock_out == (deep_idle_mode_in ? clock_generator_ref_out : clock_generator_in);
    endproperty
    a_idle: assert property (p_idle) else $error("system clock wrong");
    property p_boot;
        $rose(hw_reset_n_out) |-> ##2 boot_start_out ##1 !boot_start_out;
    endproperty
    a_boot: assert property (p_boot) else $error("boot pulse wrong");
    property p_sync;
        $rose(hw_reset_n_out) |-> $past(supply_good_out) && $past(reset_pin_n_in);
    endproperty
    a_sync: assert property (p_sync) else $error("release not synchronised");
    c_boot: cover property (boot_start_out);
    c_rise: cover property ($rose(supply_good_out) && core_regulator_enable_out);
    c_vsel: cover property ($changed(core_voltage_select_out));
endmodule // rcs_top_checker

/* sim/rcs_top_tb.sv */
// testbench for the reset and clock source select block
module rcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcs_pkg::*;
    logic clock_in = 0, rst_in = 1, reg_cfg = 1, clk_cfg = 0, pulse_req = 0;
    logic core_regulator_enable_strap_in, clock_source_strap_in, reset_pin_n_in;
    logic core_regulator_output_above_threshold_in = 0, deep_idle_mode_in = 0;
    logic external_clock_input_in = 0, rtc_oscillator_in = 0, clock_generator_in = 0;
    logic core_regulator_enable_out, core_voltage_select_out, supply_good_out, hw_reset_n_out;
    logic boot_start_out, clock_generator_ref_out, rtc_timer_clock_out, system_clock_out;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [2:0] ck_cnt = 0;
    logic [31:0] rd;
    int bad_count = 0, checks_done = 0;
    rcs_top rcs_top_inst (.clock_in, .rst_in, .core_regulator_enable_strap_in,
        .clock_source_strap_in, .reset_pin_n_in, .core_regulator_output_above_threshold_in,
        .deep_idle_mode_in, .external_clock_input_in, .rtc_oscillator_in, .clock_generator_in,
        .core_regulator_enable_out, .core_voltage_select_out, .supply_good_out,
        .hw_reset_n_out, .boot_start_out, .clock_generator_ref_out, .rtc_timer_clock_out,
        .system_clock_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rcs_board_model rcs_board_model_inst (.clock_in, .rst_in, .reg_strap_cfg_in(reg_cfg),
        .clk_strap_cfg_in(clk_cfg), .pulse_req_in(pulse_req),
        .core_regulator_enable_strap_out(core_regulator_enable_strap_in),
        .clock_source_strap_out(clock_source_strap_in), .reset_pin_n_out(reset_pin_n_in));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        ck_cnt <= ck_cnt + 3'h1;
        external_clock_input_in <= ck_cnt[0];
        rtc_oscillator_in <= ck_cnt[1];
        clock_generator_in <= ck_cnt[2];
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        resp = 2'bxx;
        do begin
            @(posedge clock_in);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end while (s_axi_bready && n < 100);
    endtask
    task automatic axi_read(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge clock_in);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        resp = 2'bxx;
        rd = 32'hxxxx_xxxx;
        do begin
            @(posedge clock_in);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
                resp = s_axi_rresp;
                rd = s_axi_rdata;
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_rready && n < 100);
    endtask
    task automatic do_reset(input logic rg, input logic ck);
        @(posedge clock_in);
        reg_cfg <= rg; clk_cfg <= ck; rst_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
    endtask
    task automatic wait_boot();
        int n;
        n = 0;
        do begin
            @(posedge clock_in);
            #1 n++;
        end while (boot_start_out !== 1'b1 && n < 40);
        check("boot_start", 32'(boot_start_out), 32'h1);
    endtask
    task automatic check_clocks(input logic sel);
        repeat (16) begin
            @(posedge clock_in);
            deep_idle_mode_in <= ck_cnt[2];
            #1 check("ref", 32'(clock_generator_ref_out),
                32'(sel ? external_clock_input_in : rtc_oscillator_in));
            check("sys", 32'(system_clock_out), 32'(deep_idle_mode_in ? clock_generator_ref_out
                : clock_generator_in));
        end
    endtask
    initial begin
        #100us;
        bad_count++;
        complete_run();
    end
    initial begin
        do_reset(1'b1, 1'b0);
        wait_boot();
        check("supply_good", 32'(supply_good_out), 32'h1);
        check("reg_enable", 32'(core_regulator_enable_out), 32'h0);
        check_clocks(1'b0);
        axi_read(ADDR_STRAPS);
        check("straps", rd, 32'h1);
        axi_write(ADDR_REG_CTRL, 32'h1);
        check("ctrl_resp", 32'(resp), 32'(RESP_OKAY));
        check("vsel", 32'(core_voltage_select_out), 32'h1);
        axi_write(ADDR_STATUS, 32'hffff_ffff);
        check("status_resp", 32'(resp), 32'(RESP_OKAY));
        axi_read(ADDR_REG_CTRL);
        check("ctrl", rd, 32'h1);
        axi_write(ADDR_REG_CTRL, 32'h0);
        check("vsel_low", 32'(core_voltage_select_out), 32'h0);
        axi_read(12'h00c);
        check("bad_resp", {rd[31:2], resp}, 32'(RESP_SLVERR));
        pulse_req <= 1'b1;
        @(posedge clock_in);
        pulse_req <= 1'b0;
        @(posedge clock_in);
        #1 check("hw_reset_pin", 32'(hw_reset_n_out), 32'h0);
        wait_boot();
        do_reset(1'b0, 1'b1);
        core_regulator_output_above_threshold_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        core_regulator_output_above_threshold_in <= 1'b0;
        repeat (20) begin
            @(posedge clock_in);
            #1 check("good_low", {supply_good_out, hw_reset_n_out}, 32'h0);
        end
        check("vsel_rst", {core_voltage_select_out, core_regulator_enable_out}, 32'h1);
        @(posedge clock_in);
        core_regulator_output_above_threshold_in <= 1'b1;
        wait_boot();
        check("good_up", 32'(supply_good_out), 32'h1);
        check_clocks(1'b1);
        @(posedge clock_in);
        core_regulator_output_above_threshold_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        #1 check("good_drop", {supply_good_out, hw_reset_n_out}, 32'h0);
        complete_run();
    end
endmodule // rcs_top_tb
bind rcs_top rcs_top_checker rcs_top_checker_inst (.clock_in, .rst_in, .clock_source_strap_in,
    .reset_pin_n_in, .core_regulator_output_above_threshold_in, .deep_idle_mode_in,
    .external_clock_input_in, .rtc_oscillator_in, .clock_generator_in,
    .core_regulator_enable_out, .core_voltage_select_out, .supply_good_out, .hw_reset_n_out,
    .boot_start_out, .clock_generator_ref_out, .rtc_timer_clock_out, .system_clock_out,
    .s_axi_bvalid);
